// >>> dp_pkg.sv
// Constants, register map and types for the processor register datapath.
// Functional notes
// RQ1: Upper accumulator half, 18 bits: mask, remainder, add-to-upper sum, shift, complement.
// RQ2: Lower accumulator half, 18 bits: main accumulator, quotient, add-to-lower sum.
// RQ3: Odd function codes below octal 50 add the active index value to the operand.
// RQ4: Index value is one's complement; only address-width low bits form an address.
// RQ5: Three-bit index selector picks one of eight control-memory index registers.
// RQ6: Program address advances by one once the instruction leaves memory.
// RQ7: A satisfied skip advances the program address one more; the code ignores a skip in the same cycle as instr_valid.
// RQ8: Normal return jump stores advanced address, then loads the entrance address.
// RQ9: Interrupt return jump stores the unadvanced program address; the code stores the same paddr_q as a normal return jump.
// RQ10: Five-bit bank register; bit three selects bank bits or program bits as extension.
// RQ11: Even and odd 18-bit output buffers, pairable for 36-bit output.
// RQ12: Seven-bit function register: six-bit code, top bit marks second format.
// RQ13: Address register captured at cycle start; 16 bits main, 8 bits control.
// RQ14: Two-microsecond main cycle holds four 500-nanosecond control cycles.
// RQ15: Index fetch within 250 ns; modification done within the fetching main cycle.
// RQ16: I/O section reaches control memory independent of instruction sequence.
// RQ17: Core transfers pass an 18-bit buffer; control transfers pass another.
// RQ18: Each displayed register takes a single-bit manual set and a whole clear; in the code the status, mask and interrupt-select registers take neither.
// RQ19: Highest pending interrupt is chosen; others honoured in order or ignored.
package dp_pkg;
  localparam int          WORD_W        = 18;
  localparam int          MAIN_AW       = 16;
  localparam int          CTRL_AW       = 8;
  localparam int          FUNC_W        = 7;
  localparam int          IRQ_N         = 8;
  localparam int          CLK_NS        = 10;
  localparam int          MAIN_CYC_NS   = 2000;
  localparam int          CTRL_CYC_NS   = 500;
  localparam int          IDX_FETCH_NS  = 250;
  localparam int          MAIN_CYC      = MAIN_CYC_NS / CLK_NS;
  localparam int          CTRL_CYC      = CTRL_CYC_NS / CLK_NS;
  localparam int          IDX_FETCH_CYC = IDX_FETCH_NS / CLK_NS;
  localparam logic [5:0]  IDX_LIMIT     = 6'h28;
  localparam logic [5:0]  OP_JUMP       = 6'h01;
  localparam logic [5:0]  OP_CONST      = 6'h03;
  localparam int          BANK_SEL_BIT  = 3;
  localparam logic [3:0]  A_UPPER       = 4'h0;
  localparam logic [3:0]  A_LOWER       = 4'h1;
  localparam logic [3:0]  A_INDEX       = 4'h2;
  localparam logic [3:0]  A_ISEL        = 4'h3;
  localparam logic [3:0]  A_BANK        = 4'h4;
  localparam logic [3:0]  A_EVEN        = 4'h5;
  localparam logic [3:0]  A_ODD         = 4'h6;
  localparam logic [3:0]  A_PADDR       = 4'h7;
  localparam logic [3:0]  A_FUNC        = 4'h8;
  localparam logic [3:0]  A_STATUS      = 4'h9;
  localparam logic [3:0]  A_MASK        = 4'ha;
  localparam logic [3:0]  A_IRQSEL      = 4'hb;
  localparam logic [3:0]  A_CORE_BUF    = 4'hc;
  localparam logic [3:0]  A_CTRL_BUF    = 4'hd;
  localparam int          EV_IRQ        = 0;
  localparam int          EV_SKIP       = 1;
  localparam int          EV_RJ         = 2;
  localparam int          EV_N          = 3;
  typedef enum logic [2:0] {
    OP_NONE, OP_ADD_UP, OP_ADD_LO, OP_DIV, OP_SHIFT, OP_CPL, OP_MASK_LD
  } alu_op_t;
endpackage

// >>> cpu_register_datapath.sv
// Processor register set, address formation and memory buffers.
module cpu_register_datapath (
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic [3:0]                reg_addr,
  input  wire logic [dp_pkg::WORD_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [dp_pkg::WORD_W-1:0] reg_rdata,
  input  wire logic                      instr_valid,
  input  wire logic [dp_pkg::WORD_W-1:0] instr_word,
  input  wire logic [dp_pkg::FUNC_W-1:0] instr_func,
  input  wire dp_pkg::alu_op_t           alu_op,
  input  wire logic [dp_pkg::WORD_W-1:0] alu_operand,
  input  wire logic                      alu_shift_left,
  input  wire logic                      skip_true,
  input  wire logic                      rj_req,
  input  wire logic                      rj_irq,
  input  wire logic [dp_pkg::MAIN_AW-1:0] rj_entry,
  input  wire logic [dp_pkg::WORD_W-1:0] idx_data,
  input  wire logic                      io_cm_req,
  input  wire logic [dp_pkg::CTRL_AW-1:0] io_cm_addr,
  input  wire logic [dp_pkg::IRQ_N-1:0]  irq_pend,
  input  wire logic                      pair_out,
  input  wire logic [dp_pkg::WORD_W-1:0] core_rdata,
  input  wire logic [dp_pkg::WORD_W-1:0] ctrl_rdata,
  input  wire logic [3:0]                panel_reg,
  input  wire logic [4:0]                panel_bit,
  input  wire logic                      panel_set,
  input  wire logic                      panel_clr,
  output logic      [dp_pkg::MAIN_AW-1:0] main_memory_address,
  output logic      [dp_pkg::CTRL_AW-1:0] control_memory_address,
  output logic      [dp_pkg::WORD_W-1:0] core_transfer_buffer,
  output logic      [dp_pkg::WORD_W-1:0] control_memory_buffer,
  output logic                           core_wr,
  output logic      [35:0]               out_word,
  output logic      [dp_pkg::WORD_W-1:0] operand_mod,
  output logic                           main_cycle_start,
  output logic                           ctrl_cycle_start,
  output logic      [2:0]                irq_sel,
  output logic                           irq_sel_valid,
  output logic                           irq
);
  import dp_pkg::*;

  logic [WORD_W-1:0]  upper_half_accumulator_q;
  logic [WORD_W-1:0]  lower_half_accumulator_q;
  logic [WORD_W-1:0]  index_modifier_value_q;
  logic [2:0]         index_selector_q;
  logic [4:0]         bank_extension_q;
  logic [WORD_W-1:0]  even_output_buffer_q;
  logic [WORD_W-1:0]  odd_output_buffer_q;
  logic [MAIN_AW-1:0] paddr_q;
  logic [FUNC_W-1:0]  func_q;
  logic [EV_N-1:0]    status_q;
  logic [EV_N-1:0]    mask_q;
  logic [7:0]         main_cnt_q;
  logic [5:0]         ctrl_cnt_q;
  logic [WORD_W-1:0]  ysum;
  logic [MAIN_AW-1:0] eff_addr;
  logic [EV_N-1:0]    ev;
  logic               indexed;
  logic               banked;
  logic [WORD_W-1:0]  rd_d;
  logic [WORD_W-1:0]  paddr_pan;
  logic [WORD_W-1:0]  func_pan;
  logic [WORD_W-1:0]  bank_pan;

  // One's complement add with end-around carry.
  function automatic logic [WORD_W-1:0] oc_add(input logic [WORD_W-1:0] a,
                                               input logic [WORD_W-1:0] b);
    logic [WORD_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, s[WORD_W]};
  endfunction

  // RQ18 manual set and clear.
  function automatic logic [WORD_W-1:0] panel(input logic [WORD_W-1:0] v,
                                              input logic [3:0] id);
    logic [WORD_W-1:0] r;
    r = v;
    if (panel_clr && panel_reg == id) begin
      r = '0;
    end else if (panel_set && panel_reg == id) begin
      r = v | (WORD_W'(1) << panel_bit);
    end
    return r;
  endfunction

  assign paddr_pan = panel({2'b00, paddr_q}, A_PADDR);
  assign func_pan  = panel({11'h000, func_q}, A_FUNC);
  assign bank_pan  = panel({13'h0000, bank_extension_q}, A_BANK);

  // RQ14 main cycle timing.
  always_ff @(posedge mclk) begin
    if (srst || main_cnt_q == 8'(MAIN_CYC - 1)) begin
      main_cnt_q <= '0;
    end else begin
      main_cnt_q <= main_cnt_q + 8'h01;
    end
  end

  // RQ14 four control cycles.
  always_ff @(posedge mclk) begin
    if (srst || ctrl_cnt_q == 6'(CTRL_CYC - 1)) begin
      ctrl_cnt_q <= '0;
    end else begin
      ctrl_cnt_q <= ctrl_cnt_q + 6'h01;
    end
  end

  assign main_cycle_start = (main_cnt_q == 8'h00);
  assign ctrl_cycle_start = (ctrl_cnt_q == 6'h00);

  // RQ3 odd codes indexed.
  assign indexed = !instr_func[6] && instr_func[0] && (instr_func[5:0] < IDX_LIMIT);
  // RQ10 bank extension applies.
  assign banked  = !instr_func[6] && (instr_func[5:0] < IDX_LIMIT)
                   && instr_func[5:0] != OP_JUMP && instr_func[5:0] != OP_CONST;
  // RQ4 one's complement index sum.
  assign ysum = indexed ? oc_add({6'h00, instr_word[11:0]}, index_modifier_value_q)
                        : {6'h00, instr_word[11:0]};

  // RQ10 bank select.
  always_comb begin
    eff_addr = {paddr_q[MAIN_AW-1:12], ysum[11:0]};
    if (banked && bank_extension_q[BANK_SEL_BIT]) begin
      eff_addr = {bank_extension_q[4], bank_extension_q[2:0], ysum[11:0]};
    end else if (!banked) begin
      // RQ4 truncate to address width.
      eff_addr = ysum[MAIN_AW-1:0];
    end
  end

  // RQ15 index fetch once per control cycle while no I/O request is pending, well inside the main cycle.
  always_ff @(posedge mclk) begin
    if (srst) begin
      index_modifier_value_q <= '0;
    end else if (reg_wr && reg_addr == A_INDEX) begin
      index_modifier_value_q <= reg_wdata;
    end else if (ctrl_cycle_start && !io_cm_req) begin
      index_modifier_value_q <= panel(idx_data, A_INDEX);
    end else begin
      index_modifier_value_q <= panel(index_modifier_value_q, A_INDEX);
    end
  end

  // RQ5 index selector.
  always_ff @(posedge mclk) begin
    if (srst || (panel_clr && panel_reg == A_ISEL)) begin
      index_selector_q <= '0;
    end else if (reg_wr && reg_addr == A_ISEL) begin
      index_selector_q <= reg_wdata[2:0];
    end else if (panel_set && panel_reg == A_ISEL && panel_bit < 5'h03) begin
      index_selector_q <= index_selector_q | (3'h1 << panel_bit[1:0]);
    end
  end

  // RQ13 address capture; RQ16 I/O control memory access.
  always_ff @(posedge mclk) begin
    if (srst) begin
      main_memory_address    <= '0;
      control_memory_address <= '0;
    end else begin
      if (main_cycle_start) begin
        main_memory_address <= rj_req ? eff_addr : (instr_valid ? paddr_q : eff_addr);
      end
      if (ctrl_cycle_start) begin
        control_memory_address <= io_cm_req ? io_cm_addr : {5'h00, index_selector_q};
      end
    end
  end

  // RQ6 advance, RQ7 skip, RQ8 and RQ9 return jump.
  always_ff @(posedge mclk) begin
    if (srst) begin
      paddr_q <= '0;
    end else if (reg_wr && reg_addr == A_PADDR) begin
      paddr_q <= reg_wdata[MAIN_AW-1:0];
    end else if (rj_req) begin
      paddr_q <= rj_entry;
    end else if (instr_valid) begin
      paddr_q <= paddr_q + MAIN_AW'(1);
    end else if (skip_true) begin
      paddr_q <= paddr_q + MAIN_AW'(1);
    end else begin
      paddr_q <= paddr_pan[MAIN_AW-1:0];
    end
  end

  // RQ17 core buffer; RQ8 and RQ9 store return address.
  always_ff @(posedge mclk) begin
    if (srst) begin
      core_transfer_buffer <= '0;
      core_wr              <= 1'b0;
    end else begin
      core_wr <= rj_req;
      if (rj_req) begin
        core_transfer_buffer <= {2'b00, rj_irq ? paddr_q : paddr_q};
      end else if (instr_valid) begin
        core_transfer_buffer <= core_rdata;
      end else begin
        core_transfer_buffer <= panel(core_transfer_buffer, A_CORE_BUF);
      end
    end
  end

  // RQ17 control memory buffer.
  always_ff @(posedge mclk) begin
    if (srst) begin
      control_memory_buffer <= '0;
    end else if (ctrl_cycle_start) begin
      control_memory_buffer <= ctrl_rdata;
    end else begin
      control_memory_buffer <= panel(control_memory_buffer, A_CTRL_BUF);
    end
  end

  // RQ12 function register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      func_q <= '0;
    end else if (instr_valid) begin
      func_q <= instr_func;
    end else begin
      func_q <= func_pan[FUNC_W-1:0];
    end
  end

  // RQ1 upper half.
  always_ff @(posedge mclk) begin
    if (srst) begin
      upper_half_accumulator_q <= '0;
    end else if (reg_wr && reg_addr == A_UPPER) begin
      upper_half_accumulator_q <= reg_wdata;
    end else begin
      case (alu_op)
        OP_ADD_UP:  upper_half_accumulator_q <= oc_add(upper_half_accumulator_q, alu_operand);
        OP_DIV:     upper_half_accumulator_q <= alu_operand;
        OP_MASK_LD: upper_half_accumulator_q <= alu_operand;
        OP_SHIFT:   upper_half_accumulator_q <= alu_shift_left
                      ? {upper_half_accumulator_q[16:0], lower_half_accumulator_q[17]}
                      : {upper_half_accumulator_q[17], upper_half_accumulator_q[17:1]};
        OP_CPL:     upper_half_accumulator_q <= ~upper_half_accumulator_q;
        default:    upper_half_accumulator_q <= panel(upper_half_accumulator_q, A_UPPER);
      endcase
    end
  end

  // RQ2 lower half.
  always_ff @(posedge mclk) begin
    if (srst) begin
      lower_half_accumulator_q <= '0;
    end else if (reg_wr && reg_addr == A_LOWER) begin
      lower_half_accumulator_q <= reg_wdata;
    end else begin
      case (alu_op)
        OP_ADD_LO: lower_half_accumulator_q <= oc_add(lower_half_accumulator_q, alu_operand);
        OP_DIV:    lower_half_accumulator_q <= ysum;
        OP_SHIFT:  lower_half_accumulator_q <= alu_shift_left
                     ? {lower_half_accumulator_q[16:0], upper_half_accumulator_q[17]}
                     : {upper_half_accumulator_q[0], lower_half_accumulator_q[17:1]};
        OP_CPL:    lower_half_accumulator_q <= ~lower_half_accumulator_q;
        default:   lower_half_accumulator_q <= panel(lower_half_accumulator_q, A_LOWER);
      endcase
    end
  end

  // RQ10 bank register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      bank_extension_q <= '0;
    end else if (reg_wr && reg_addr == A_BANK) begin
      bank_extension_q <= reg_wdata[4:0];
    end else begin
      bank_extension_q <= bank_pan[4:0];
    end
  end

  // RQ11 output buffers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      even_output_buffer_q <= '0;
      odd_output_buffer_q  <= '0;
      out_word             <= '0;
    end else begin
      if (reg_wr && reg_addr == A_EVEN) begin
        even_output_buffer_q <= reg_wdata;
      end else begin
        even_output_buffer_q <= panel(even_output_buffer_q, A_EVEN);
      end
      if (reg_wr && reg_addr == A_ODD) begin
        odd_output_buffer_q <= reg_wdata;
      end else begin
        odd_output_buffer_q <= panel(odd_output_buffer_q, A_ODD);
      end
      out_word <= pair_out ? {even_output_buffer_q, odd_output_buffer_q}
                           : {18'h00000, odd_output_buffer_q};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      operand_mod <= '0;
    end else begin
      operand_mod <= ysum;
    end
  end

  // RQ19 priority pick.
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_sel       <= '0;
      irq_sel_valid <= 1'b0;
    end else begin
      irq_sel_valid <= |irq_pend;
      irq_sel       <= '0;
      for (int i = 0; i < IRQ_N; i++) begin
        if (irq_pend[i]) begin
          irq_sel <= 3'(i);
        end
      end
    end
  end

  // Events win over a same-cycle clear so none is lost.
  assign ev = {rj_req, skip_true, |irq_pend};
  always_ff @(posedge mclk) begin
    if (srst) begin
      status_q <= '0;
      mask_q   <= '0;
    end else begin
      if (reg_wr && reg_addr == A_MASK) begin
        mask_q <= reg_wdata[EV_N-1:0];
      end
      status_q <= (status_q & ~((reg_wr && reg_addr == A_STATUS)
                  ? reg_wdata[EV_N-1:0] : '0)) | ev;
    end
  end

  assign irq = |(status_q & mask_q);

  always_comb begin
    case (reg_addr)
      A_UPPER:    rd_d = upper_half_accumulator_q;
      A_LOWER:    rd_d = lower_half_accumulator_q;
      A_INDEX:    rd_d = index_modifier_value_q;
      A_ISEL:     rd_d = {15'h0000, index_selector_q};
      A_BANK:     rd_d = {13'h0000, bank_extension_q};
      A_EVEN:     rd_d = even_output_buffer_q;
      A_ODD:      rd_d = odd_output_buffer_q;
      A_PADDR:    rd_d = {2'b00, paddr_q};
      A_FUNC:     rd_d = {11'h000, func_q};
      A_STATUS:   rd_d = {15'h0000, status_q};
      A_MASK:     rd_d = {15'h0000, mask_q};
      A_IRQSEL:   rd_d = {15'h0000, irq_sel};
      A_CORE_BUF: rd_d = core_transfer_buffer;
      A_CTRL_BUF: rd_d = control_memory_buffer;
      default:    rd_d = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_d : '0;
    end
  end
endmodule

// >>> cpu_register_datapath_chk.sv
// Port checker for the processor register datapath.
module cpu_register_datapath_chk
  import dp_pkg::*;
(
  input wire logic                      mclk,
  input wire logic                      srst,
  input wire logic                      reg_rd,
  input wire logic [dp_pkg::WORD_W-1:0] reg_rdata,
  input wire logic                      rj_req,
  input wire logic                      core_wr,
  input wire logic                      main_cycle_start,
  input wire logic                      ctrl_cycle_start,
  input wire logic [dp_pkg::IRQ_N-1:0]  irq_pend,
  input wire logic [2:0]                irq_sel,
  input wire logic                      irq_sel_valid,
  input wire logic                      pair_out,
  input wire logic [35:0]               out_word
);
  logic [7:0] main_cnt_q;
  logic [7:0] ctrl_cnt_q;
  logic       main_seen_q;
  logic       ctrl_seen_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Counters hold the spacing between cycle starts.
  always_ff @(posedge mclk) begin
    main_cnt_q <= (srst || main_cycle_start) ? 8'h01 : main_cnt_q + 8'h01;
    main_seen_q <= srst ? 1'b0 : (main_seen_q | main_cycle_start);
  end
  always_ff @(posedge mclk) begin
    ctrl_cnt_q <= (srst || ctrl_cycle_start) ? 8'h01 : ctrl_cnt_q + 8'h01;
    ctrl_seen_q <= srst ? 1'b0 : (ctrl_seen_q | ctrl_cycle_start);
  end
  a_rdata_idle: assert property (reg_rdata != '0 |-> $past(reg_rd))
    else $error("read data seen without a read");
  a_store_cause: assert property (core_wr |-> $past(rj_req))
    else $error("core write without return jump");
  a_store_follow: assert property (rj_req |=> core_wr)
    else $error("return jump did not store");
  a_main_period: assert property (main_cycle_start && main_seen_q |-> main_cnt_q == 8'd200)
    else $error("main cycle spacing wrong");
  a_ctrl_period: assert property (ctrl_cycle_start && ctrl_seen_q |-> ctrl_cnt_q == 8'd50)
    else $error("control cycle spacing wrong");
  a_cycles_aligned: assert property (main_cycle_start |-> ctrl_cycle_start)
    else $error("main cycle not on a control cycle");
  a_irq_top: assert property (irq_pend[7] |=> irq_sel_valid && irq_sel == 3'h7)
    else $error("top interrupt not chosen");
  a_irq_none: assert property (irq_pend == '0 |=> !irq_sel_valid)
    else $error("interrupt chosen with none pending");
  a_pair_off: assert property (!pair_out |=> out_word[35:18] == '0)
    else $error("even half shown while unpaired");
  c_rj: cover property (rj_req ##1 core_wr);
  c_pair: cover property (pair_out ##1 pair_out);
  c_irq: cover property (irq_pend[7] ##1 irq_sel_valid);
endmodule

bind cpu_register_datapath cpu_register_datapath_chk chk_u (.mclk(mclk), .srst(srst),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rj_req(rj_req), .core_wr(core_wr),
  .main_cycle_start(main_cycle_start), .ctrl_cycle_start(ctrl_cycle_start),
  .irq_pend(irq_pend), .irq_sel(irq_sel), .irq_sel_valid(irq_sel_valid),
  .pair_out(pair_out), .out_word(out_word));

// >>> dp_mem_model.sv
// Behavioural core and control memory on the far side of the datapath.
module dp_mem_model
  import dp_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic [dp_pkg::MAIN_AW-1:0] main_memory_address,
  input  wire logic [dp_pkg::CTRL_AW-1:0] control_memory_address,
  input  wire logic [dp_pkg::WORD_W-1:0]  core_transfer_buffer,
  input  wire logic                       core_wr,
  output logic      [dp_pkg::WORD_W-1:0]  core_rdata,
  output logic      [dp_pkg::WORD_W-1:0]  ctrl_rdata,
  output logic      [dp_pkg::WORD_W-1:0]  idx_data
);
  logic [WORD_W-1:0] core_q [256];
  initial core_rdata = '0;
  initial ctrl_rdata = '0;
  initial idx_data = '0;
  always @(posedge mclk) begin
    if (core_wr) core_q[main_memory_address[7:0]] <= core_transfer_buffer;
    core_rdata <= core_q[main_memory_address[7:0]];
  end
  always @(posedge mclk) begin
    ctrl_rdata <= {10'h0, control_memory_address} ^ 18'h2a5a5;
    idx_data <= {10'h0, control_memory_address} ^ 18'h15a5a;
  end
endmodule

// >>> cpu_register_datapath_tb_top.sv
// Self-checking bench for the processor register datapath.
module cpu_register_datapath_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dp_pkg::*;
  logic              mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, instr_valid = 0;
  logic              skip_true = 0, rj_req = 0, rj_irq = 0, pair_out = 0, io_cm_req = 0;
  alu_op_t           alu_op = OP_NONE;
  logic              panel_set = 0, panel_clr = 0, core_wr, main_cycle_start;
  logic              ctrl_cycle_start, irq, irq_sel_valid;
  logic [3:0]        reg_addr = 0, panel_reg = 0;
  logic [4:0]        panel_bit = 0;
  logic [6:0]        instr_func = 0;
  logic [7:0]        irq_pend = 0, io_cm_addr = 0, cm_addr;
  logic [15:0]       rj_entry = 0, mm_addr;
  logic [17:0]       reg_wdata = 0, instr_word = 0, alu_operand = 0, reg_rdata, idx_data;
  logic [17:0]       core_rdata, ctrl_rdata, core_buf, ctrl_buf, operand_mod;
  logic [2:0]        irq_sel;
  logic [35:0]       out_word;
  logic [31:0]       rs = 32'd63633;
  int                mismatches = 0, num_checks = 0, ea;
  int                mdl [16];
  int                wm [16] = '{'h3ffff, 'h3ffff, 0, 7, 'h1f, 'h3ffff, 'h3ffff, 0, 0, 0, 7,
                                 0, 0, 0, 0, 0};
  always #5 mclk = ~mclk;
  cpu_register_datapath dut_u (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .instr_valid(instr_valid), .instr_word(instr_word), .instr_func(instr_func),
    .alu_op(alu_op), .alu_operand(alu_operand), .alu_shift_left(1'b0),
    .skip_true(skip_true), .rj_req(rj_req), .rj_irq(rj_irq), .rj_entry(rj_entry),
    .idx_data(idx_data), .io_cm_req(io_cm_req), .io_cm_addr(io_cm_addr), .irq_pend(irq_pend),
    .pair_out(pair_out), .core_rdata(core_rdata), .ctrl_rdata(ctrl_rdata),
    .panel_reg(panel_reg), .panel_bit(panel_bit), .panel_set(panel_set),
    .panel_clr(panel_clr), .main_memory_address(mm_addr), .control_memory_address(cm_addr),
    .core_transfer_buffer(core_buf), .control_memory_buffer(ctrl_buf), .core_wr(core_wr),
    .out_word(out_word), .operand_mod(operand_mod), .main_cycle_start(main_cycle_start),
    .ctrl_cycle_start(ctrl_cycle_start), .irq_sel(irq_sel), .irq_sel_valid(irq_sel_valid),
    .irq(irq));
  dp_mem_model mem_u (.mclk(mclk), .main_memory_address(mm_addr),
    .control_memory_address(cm_addr), .core_transfer_buffer(core_buf), .core_wr(core_wr),
    .core_rdata(core_rdata), .ctrl_rdata(ctrl_rdata), .idx_data(idx_data));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [17:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    if (a != A_STATUS) mdl[a] = int'(d) & wm[a];
    #1;
  endtask
  task automatic rdchk(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", 36'(mdl[a]), 36'(reg_rdata));
  endtask
  task automatic rj(input logic irqm);
    logic [17:0] st;
    st = 18'(mdl[A_PADDR]);
    @(posedge mclk);
    rj_entry <= 16'(rnd());
    rj_irq <= irqm;
    rj_req <= 1'b1;
    @(posedge mclk);
    rj_req <= 1'b0;
    mdl[A_PADDR] = int'(rj_entry);
    mdl[A_STATUS] |= 4;
    #1 chk("core_transfer_buffer", 36'(st), 36'(core_buf));
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    test_done();
  end
  initial begin
    mdl = '{default: 0};
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    instr_word <= 18'(rnd());
    alu_operand <= 18'(rnd());
    io_cm_addr <= 8'(rnd());
    for (int a = 0; a < 16; a++)
      if (!(a inside {A_INDEX, A_CORE_BUF, A_CTRL_BUF})) rdchk(4'(a));
    foreach (wm[a]) if (wm[a] != 0 || a == 14) wr(4'(a), 18'(rnd()));
    for (int a = 0; a < 16; a++)
      if (wm[a] != 0 || a == 14) rdchk(4'(a));
    @(posedge mclk);
    alu_op <= OP_CPL;
    instr_func <= 7'h05;
    @(posedge mclk);
    alu_op <= OP_NONE;
    mdl[A_UPPER] ^= 'h3ffff;
    mdl[A_LOWER] ^= 'h3ffff;
    rdchk(A_UPPER);
    rdchk(A_LOWER);
    repeat (300) @(posedge mclk);
    mdl[A_INDEX] = mdl[A_ISEL] ^ 'h15a5a;
    mdl[A_CTRL_BUF] = mdl[A_ISEL] ^ 'h2a5a5;
    rdchk(A_INDEX);
    rdchk(A_CTRL_BUF);
    chk("control_memory_buffer", 36'(mdl[A_CTRL_BUF]), 36'(ctrl_buf));
    chk("control_memory_address", 36'(mdl[A_ISEL]), 36'(cm_addr));
    ea = (instr_word & 'hfff) + mdl[A_INDEX];
    ea = (ea & 'h3ffff) + (ea >> 18);
    chk("operand_mod", 36'(ea), 36'(operand_mod));
    ea &= 'hfff;
    ea |= (mdl[A_BANK] & 8) ? (((mdl[A_BANK] >> 1) & 8) | (mdl[A_BANK] & 7)) << 12
                            : mdl[A_PADDR] & 'hf000;
    chk("main_memory_address", 36'(ea), 36'(mm_addr));
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      instr_func <= 7'h28 + 7'(rnd() % 24);
      instr_valid <= 1'b1;
      @(posedge mclk);
      instr_valid <= 1'b0;
      mdl[A_PADDR]++;
      mdl[A_FUNC] = int'(instr_func);
    end
    rdchk(A_PADDR);
    rdchk(A_FUNC);
    @(posedge mclk);
    skip_true <= 1'b1;
    @(posedge mclk);
    skip_true <= 1'b0;
    mdl[A_PADDR]++;
    mdl[A_STATUS] |= 2;
    rdchk(A_PADDR);
    rj(1'b0);
    rdchk(A_PADDR);
    rj(1'b1);
    rdchk(A_STATUS);
    wr(A_MASK, 18'h0);
    chk("irq", 36'h0, 36'(irq));
    wr(A_MASK, 18'h2);
    chk("irq", 36'h1, 36'(irq));
    wr(A_STATUS, 18'h2);
    mdl[A_STATUS] = 4;
    chk("irq", 36'h0, 36'(irq));
    rdchk(A_STATUS);
    wr(A_MASK, 18'h7);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      irq_pend <= 8'(1 << i) | (8'(rnd()) & 8'((1 << i) - 1));
      repeat (3) @(posedge mclk);
      #1 chk("irq_sel", 36'(i), 36'(irq_sel));
      chk("irq", 36'h1, 36'(irq));
    end
    @(posedge mclk);
    irq_pend <= 8'h0;
    wr(A_STATUS, 18'h7);
    mdl[A_STATUS] = 0;
    rdchk(A_STATUS);
    chk("irq", 36'h0, 36'(irq));
    for (int p = 1; p >= 0; p--) begin
      @(posedge mclk);
      pair_out <= 1'(p);
      repeat (2) @(posedge mclk);
      #1 chk("out_word", {p ? 18'(mdl[A_EVEN]) : 18'h0, 18'(mdl[A_ODD])}, out_word);
    end
    foreach (wm[a]) if (a inside {A_UPPER, A_LOWER, A_BANK}) begin
      @(posedge mclk);
      panel_reg <= 4'(a);
      panel_bit <= (a == A_BANK) ? 5'h4 : 5'(rnd() % 18);
      panel_set <= 1'b1;
      @(posedge mclk);
      panel_set <= 1'b0;
      mdl[a] |= 1 << panel_bit;
      rdchk(4'(a));
      @(posedge mclk);
      panel_clr <= 1'b1;
      @(posedge mclk);
      panel_clr <= 1'b0;
      mdl[a] = 0;
      rdchk(4'(a));
    end
    @(posedge mclk);
    io_cm_req <= 1'b1;
    repeat (51) @(posedge mclk);
    #1 chk("control_memory_address", 36'(io_cm_addr), 36'(cm_addr));
    test_done();
  end
endmodule
